/* File: rtl/lvm_top.sv */
// supply monitor response: registers, flags, reset request, interrupt, bus divider
`timescale 1ns/10ps
`default_nettype none
module lvm_top
	import lvm_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// avalon-mm slave
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// analogue comparators
	input  wire logic        DROP_DETECT,
	input  wire logic        WARN_DETECT,
	output logic             DETECT_RANGE_HIGH,
	output logic             WARN_RANGE_HIGH,
	// core opcode stream
	input  wire logic [7:0]  OPCODE,
	input  wire logic        OPCODE_VALID,
	input  wire logic        USER_MODE,
	input  wire logic [3:0]  CORE_VERSION,
	// system outputs
	output logic             SYS_RESET_REQ,
	output logic             BUS_CLK_EN,
	output logic             IRQ
);
	logic        ack;
	logic        wr_take;
	logic [4:0]  adr;
	logic [7:0]  wd;
	logic        detect_en;
	logic        stop_en;
	logic        reset_en;
	logic        drop_ie;
	logic        drop_flag;
	logic        warn_ie;
	logic        warn_high;
	logic        detect_high;
	logic        warn_flag;
	logic [7:0]  clk_two;
	logic [1:0]  irq_status;
	logic [1:0]  irq_enable;
	logic [1:0]  irq_event;
	logic [1:0]  irq_clear;
	logic        drop_hit;
	logic        drop_ack;
	logic        warn_ack;
	logic        illegal;
	logic [31:0] next_readdata;

	// bus slave: one wait state, then the access completes
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			ack <= 1'b0;
		else
			ack <= (AVS_READ || AVS_WRITE) && !ack;
	end

	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
	assign wr_take         = AVS_WRITE && ack;
	assign adr             = AVS_ADDRESS;
	assign wd              = AVS_WRITEDATA[7:0];

	always_comb
	begin
		next_readdata = 32'h0;
		unique case (adr)
			OFS_CTL_ONE:
			begin
				next_readdata[B1_DROP_FLAG] = drop_flag;
				next_readdata[B1_IRQ_EN]    = drop_ie;
				next_readdata[B1_RESET_EN]  = reset_en;
				next_readdata[B1_STOP_EN]   = stop_en;
				next_readdata[B1_DETECT_EN] = detect_en;
			end
			OFS_CTL_THREE:
			begin
				next_readdata[B3_WARN_FLAG] = warn_flag;
				next_readdata[B3_DETECT_HI] = detect_high;
				next_readdata[B3_WARN_HIGH] = warn_high;
				next_readdata[B3_WARN_IE]   = warn_ie;
			end
			OFS_CLK_TWO:  next_readdata[7:0] = clk_two;
			OFS_IRQ_STAT: next_readdata[1:0] = irq_status;
			OFS_IRQ_EN:   next_readdata[1:0] = irq_enable;
			default:      next_readdata = 32'h0;
		endcase
	end

	// data is latched in the waited cycle so it stands at the completing edge
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			AVS_READDATA <= 32'h0;
		else if (AVS_READ && !ack)
			AVS_READDATA <= next_readdata;
	end

	// control one: drop detector set-up
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			{drop_ie, reset_en, stop_en, detect_en} <= RST_CTL_ONE[5:2];
		else if (wr_take && adr == OFS_CTL_ONE)
			{drop_ie, reset_en, stop_en, detect_en} <= wd[B1_IRQ_EN:B1_DETECT_EN];
	end

	assign drop_hit = detect_en && DROP_DETECT;
	assign drop_ack = wr_take && adr == OFS_CTL_ONE && wd[B1_DROP_ACK];

	// drop flag: a new detection wins over a simultaneous acknowledge
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			drop_flag <= 1'b0;
		else if (drop_hit)
			drop_flag <= 1'b1;
		else if (drop_ack)
			drop_flag <= 1'b0;
	end

	// control three: ranges and warning interrupt enable
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			{detect_high, warn_high, warn_ie} <= RST_CTL_THREE;
		else if (wr_take && adr == OFS_CTL_THREE)
			{detect_high, warn_high, warn_ie} <= wd[B3_DETECT_HI:B3_WARN_IE];
	end

	assign DETECT_RANGE_HIGH = detect_high;
	assign WARN_RANGE_HIGH   = warn_high;
	assign warn_ack = wr_take && adr == OFS_CTL_THREE && wd[B3_WARN_ACK];

	// warning flag is independent of the enable so polling still sees it
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			warn_flag <= 1'b0;
		else if (WARN_DETECT)
			warn_flag <= 1'b1;
		else if (warn_ack)
			warn_flag <= 1'b0;
	end

	// clock generator control two, divider takes effect on the next edge
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			clk_two <= RST_CLK_TWO;
		else if (wr_take && adr == OFS_CLK_TWO)
			clk_two <= wd;
	end

	lvm_bus_div u_div (
		.clk     (CLK),
		.rst     (SYS_RST),
		.div_sel (clk_two[B2_DIV_LSB+1:B2_DIV_LSB]),
		.bus_en  (BUS_CLK_EN)
	);

	lvm_op_check u_op (
		.clk          (CLK),
		.rst          (SYS_RST),
		.opcode       (OPCODE),
		.op_valid     (OPCODE_VALID),
		.user_mode    (USER_MODE),
		.core_version (CORE_VERSION),
		.illegal      (illegal)
	);

	// reset request only from the drop detector or an illegal opcode, never the warning
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			SYS_RESET_REQ <= 1'b0;
		else
			SYS_RESET_REQ <= (drop_hit && reset_en) || illegal;
	end

	// interrupt sources: warning and drop, each gated by its own enable
	assign irq_event[IB_WARN] = warn_flag && warn_ie;
	assign irq_event[IB_DROP] = drop_flag && drop_ie && !reset_en;
	assign irq_clear = (wr_take && adr == OFS_IRQ_CLR) ? wd[1:0] : 2'h0;

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			irq_status <= 2'h0;
		else
			irq_status <= irq_event | (irq_status & ~irq_clear);
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			irq_enable <= RST_IRQ_EN;
		else if (wr_take && adr == OFS_IRQ_EN)
			irq_enable <= wd[1:0];
	end

	assign IRQ = |(irq_status & irq_enable);

	// checks
	a_drop_reset_resp: assert property (@(posedge CLK) disable iff (SYS_RST)
		drop_hit && reset_en |=> SYS_RESET_REQ)
		else $error("drop with reset response gave no reset request");

	a_warn_never_resets: assert property (@(posedge CLK) disable iff (SYS_RST)
		$rose(SYS_RESET_REQ) |-> $past(drop_hit && reset_en) || $past(illegal))
		else $error("reset request without drop or illegal opcode");

	a_bg_entry_reset: assert property (@(posedge CLK) disable iff (SYS_RST)
		OPCODE_VALID && OPCODE == OP_BG_ENTRY && USER_MODE |=> ##1 SYS_RESET_REQ)
		else $error("background opcode in user mode did not reset");

	a_paged_ops_legal: assert property (@(posedge CLK) disable iff (SYS_RST)
		OPCODE_VALID && (OPCODE == OP_PAGE_RTN || OPCODE == OP_PAGE_CAL)
		&& CORE_VERSION >= PAGED_CORE_VERSION |=> !illegal)
		else $error("paged opcode flagged illegal on new core");

	a_div_immediate: assert property (@(posedge CLK) disable iff (SYS_RST)
		wr_take && adr == OFS_CLK_TWO && wd[7:6] == DIV_FULL |=> BUS_CLK_EN [*3])
		else $error("undivided bus clock not effective at once");

	a_div_quarter: assert property (@(posedge CLK) disable iff (SYS_RST)
		BUS_CLK_EN && clk_two[7:6] == DIV_QUARTER && $past(clk_two[7:6]) == DIV_QUARTER
		&& $past(clk_two[7:6], 2) == DIV_QUARTER && $past(clk_two[7:6], 3) == DIV_QUARTER
		|-> !$past(BUS_CLK_EN) && !$past(BUS_CLK_EN, 2) && !$past(BUS_CLK_EN, 3))
		else $error("quarter rate enable spacing wrong");

	a_warn_flag_set: assert property (@(posedge CLK) disable iff (SYS_RST)
		WARN_DETECT |=> warn_flag)
		else $error("warning flag not set by detector");

	a_warn_ack_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
		warn_ack && !WARN_DETECT |=> !warn_flag)
		else $error("acknowledge did not clear warning flag");

	a_warn_irq_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
		warn_flag && warn_ie && irq_enable[IB_WARN] |=> IRQ)
		else $error("enabled warning raised no interrupt");

	a_init_one: assert property (@(posedge CLK) disable iff (SYS_RST)
		wr_take && adr == OFS_CTL_ONE && wd == 8'h1c |=> detect_en && reset_en && !drop_ie)
		else $error("control one set-up not applied");

	a_init_three: assert property (@(posedge CLK) disable iff (SYS_RST)
		wr_take && adr == OFS_CTL_THREE && wd == 8'h38 |=> detect_high && warn_high && warn_ie)
		else $error("control three high set-up not applied");

	a_warn_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
		warn_flag && !warn_ack |=> warn_flag)
		else $error("warning flag dropped without acknowledge");

	c_warn_irq: cover property (@(posedge CLK) disable iff (SYS_RST) $rose(IRQ));
	c_drop_reset: cover property (@(posedge CLK) disable iff (SYS_RST) $rose(SYS_RESET_REQ));
	c_div_change: cover property (@(posedge CLK) disable iff (SYS_RST)
		wr_take && adr == OFS_CLK_TWO ##1 wr_take && adr == OFS_CTL_THREE);

endmodule : lvm_top
`default_nettype wire

/* File: rtl/lvm_pkg.sv */
// constants and helpers for the low voltage monitor response block
// Contract
// - The drop detector answers a low supply with a reset or an interrupt, set by control bits.
// - The early warning detector never causes a reset; it can only request an interrupt.
// - Background entry opcode 0x82 executed in user mode is illegal and forces a reset.
// - On core version 4 and later opcodes 0x8D and 0xAC are legal and cause no reset.
// - The divider field takes a write at any time and the bus clock changes rate at once.
// - The bus divider field encodes 0 as undivided, 1 as half and 2 as quarter frequency.
// - The warning flag reads 1 while or once the supply is below the warning threshold.
// - Writing 1 to the warning acknowledge bit clears the warning flag and stores nothing.
// - Writing 0x1C to control register one enables the drop detector with reset response.
// - Writing 0x38 to control three selects both high ranges and warning irq, 0x18 low detect.
package lvm_pkg;

	// register byte offsets
	localparam logic [4:0] OFS_CTL_ONE   = 5'h00;
	localparam logic [4:0] OFS_CTL_THREE = 5'h04;
	localparam logic [4:0] OFS_CLK_TWO   = 5'h08;
	localparam logic [4:0] OFS_IRQ_STAT  = 5'h0c;
	localparam logic [4:0] OFS_IRQ_CLR   = 5'h10;
	localparam logic [4:0] OFS_IRQ_EN    = 5'h14;

	// supply_monitor_control_one fields
	localparam int B1_DETECT_EN  = 2;
	localparam int B1_STOP_EN    = 3;
	localparam int B1_RESET_EN   = 4;
	localparam int B1_IRQ_EN     = 5;
	localparam int B1_DROP_ACK   = 6;
	localparam int B1_DROP_FLAG  = 7;
	localparam logic [5:0] RST_CTL_ONE = 6'h1c;

	// supply_monitor_control_three fields
	localparam int B3_WARN_IE    = 3;
	localparam int B3_WARN_HIGH  = 4;
	localparam int B3_DETECT_HI  = 5;
	localparam int B3_WARN_ACK   = 6;
	localparam int B3_WARN_FLAG  = 7;
	localparam logic [2:0] RST_CTL_THREE = 3'h0;

	// clock_gen_control_two fields
	localparam int B2_DIV_LSB    = 6;
	localparam logic [7:0] RST_CLK_TWO = 8'h00;
	localparam logic [1:0] DIV_FULL    = 2'h0;
	localparam logic [1:0] DIV_HALF    = 2'h1;
	localparam logic [1:0] DIV_QUARTER = 2'h2;

	// interrupt status, clear and enable layout
	localparam int IB_WARN = 0;
	localparam int IB_DROP = 1;
	localparam logic [1:0] RST_IRQ_EN = 2'h3;

	// opcodes
	localparam logic [7:0] OP_BG_ENTRY = 8'h82;
	localparam logic [7:0] OP_PAGE_RTN = 8'h8d;
	localparam logic [7:0] OP_PAGE_CAL = 8'hac;
	localparam logic [3:0] PAGED_CORE_VERSION = 4'h4;

	function automatic logic lvm_illegal_op(input logic [7:0] op, input logic user,
		input logic [3:0] ver);
		logic paged;
		paged = (op == OP_PAGE_RTN) || (op == OP_PAGE_CAL);
		return ((op == OP_BG_ENTRY) && user) || (paged && (ver < PAGED_CORE_VERSION));
	endfunction : lvm_illegal_op

	// low bits of the free counter that must be zero for a bus clock enable
	function automatic logic [1:0] lvm_div_mask(input logic [1:0] sel);
		unique case (sel)
			DIV_FULL: return 2'h0;
			DIV_HALF: return 2'h1;
			default:  return 2'h3;
		endcase
	endfunction : lvm_div_mask

endpackage : lvm_pkg

/* File: rtl/lvm_bus_div.sv */
// bus clock enable divider with immediate ratio change
`timescale 1ns/10ps
`default_nettype none
module lvm_bus_div
	import lvm_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// ratio and enable
	input  wire logic [1:0] div_sel,
	output logic            bus_en
);
	logic [1:0] count;

	always_ff @(posedge clk)
	begin
		if (rst)
			count <= 2'h0;
		else
			count <= count + 2'h1;
	end

	// free counter masked by the live ratio, so a new ratio acts on the next edge
	assign bus_en = (count & lvm_div_mask(div_sel)) == 2'h0;

endmodule : lvm_bus_div
`default_nettype wire

/* File: rtl/lvm_op_check.sv */
// illegal opcode detector feeding the reset request
`timescale 1ns/10ps
`default_nettype none
module lvm_op_check
	import lvm_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// executed opcode
	input  wire logic [7:0] opcode,
	input  wire logic       op_valid,
	input  wire logic       user_mode,
	input  wire logic [3:0] core_version,
	// result
	output logic            illegal
);
	always_ff @(posedge clk)
	begin
		if (rst)
			illegal <= 1'b0;
		else
			illegal <= op_valid && lvm_illegal_op(opcode, user_mode, core_version);
	end

endmodule : lvm_op_check
`default_nettype wire

/* File: test/lvm_top_tb_top.sv */
// self-checking bench for the supply monitor response block
`timescale 1ns/10ps
`default_nettype none
module lvm_top_tb_top
	import lvm_pkg::*;
;
	logic        CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic [4:0]  AVS_ADDRESS = 5'h00;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        DROP_DETECT = 1'b0;
	logic        WARN_DETECT = 1'b0;
	logic        DETECT_RANGE_HIGH;
	logic        WARN_RANGE_HIGH;
	logic [7:0]  OPCODE = 8'h00;
	logic        OPCODE_VALID = 1'b0;
	logic        USER_MODE = 1'b1;
	logic [3:0]  CORE_VERSION = 4'h4;
	logic        SYS_RESET_REQ;
	logic        BUS_CLK_EN;
	logic        IRQ;
	int          bad_count = 0;
	int          checks = 0;
	logic [31:0] rd;
	logic [31:0] cnt;
	logic [7:0]  op_t [5] = '{8'h82, 8'h82, 8'h8d, 8'hac, 8'h9d};
	logic        usr_t [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [3:0]  ver_t [5] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h4};
	logic [31:0] hit_t [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
	logic [1:0]  div_t [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
	logic [31:0] en_t [4] = '{32'h4, 32'h10, 32'h8, 32'h4};
	localparam int P_IRQ = 0;
	localparam int P_RST = 1;
	localparam int P_DRH = 2;
	localparam int P_WRH = 3;

	always #10 CLK = ~CLK;

	lvm_top u_lvm_top (
		.CLK(CLK), .SYS_RST(SYS_RST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST),
		.DROP_DETECT(DROP_DETECT), .WARN_DETECT(WARN_DETECT),
		.DETECT_RANGE_HIGH(DETECT_RANGE_HIGH), .WARN_RANGE_HIGH(WARN_RANGE_HIGH),
		.OPCODE(OPCODE), .OPCODE_VALID(OPCODE_VALID), .USER_MODE(USER_MODE),
		.CORE_VERSION(CORE_VERSION), .SYS_RESET_REQ(SYS_RESET_REQ),
		.BUS_CLK_EN(BUS_CLK_EN), .IRQ(IRQ)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// starts one edge after the caller so strobes never toggle twice in a step
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int k;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		k = 0;
		do
		begin
			@(posedge CLK);
			k++;
		end
		while (AVS_WAITREQUEST !== 1'b0 && k < 50);
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		if (k >= 50)
			chk(32'h1, 32'h0);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask : rdc

	// output is read at the next edge, after the previous edge's update settled
	task automatic pin(input int sel, input logic exp);
		logic v;
		@(posedge CLK);
		case (sel)
			P_IRQ:   v = IRQ;
			P_RST:   v = SYS_RESET_REQ;
			P_DRH:   v = DETECT_RANGE_HIGH;
			default: v = WARN_RANGE_HIGH;
		endcase
		chk({31'h0, v}, {31'h0, exp});
	endtask : pin

	task automatic pulse(input logic drop);
		@(posedge CLK);
		if (drop)
			DROP_DETECT <= 1'b1;
		else
			WARN_DETECT <= 1'b1;
		@(posedge CLK);
		DROP_DETECT <= 1'b0;
		WARN_DETECT <= 1'b0;
		repeat (3) @(posedge CLK);
	endtask : pulse

	task automatic final_report();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	// whole sequence needs well under 2000 cycles
	initial
	begin
		#200000;
		bad_count++;
		final_report();
	end

	initial
	begin
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		rdc(OFS_CTL_ONE, 32'h1c);
		rdc(OFS_CTL_THREE, 32'h0);
		rdc(OFS_CLK_TWO, 32'h0);
		rdc(OFS_IRQ_STAT, 32'h0);
		rdc(OFS_IRQ_CLR, 32'h0);
		rdc(OFS_IRQ_EN, 32'h3);
		wr(5'h18, 8'hff);
		rdc(5'h18, 32'h0);
		rdc(OFS_CTL_ONE, 32'h1c);
		wr(OFS_CTL_THREE, 8'h38);
		pin(P_DRH, 1'b1);
		pin(P_WRH, 1'b1);
		rdc(OFS_CTL_THREE, 32'h38);
		wr(OFS_CTL_THREE, 8'h18);
		pin(P_DRH, 1'b0);
		pin(P_WRH, 1'b1);
		// warning with its interrupt enabled, then disabled
		pulse(1'b0);
		pin(P_IRQ, 1'b1);
		pin(P_RST, 1'b0);
		rdc(OFS_CTL_THREE, 32'h98);
		rdc(OFS_IRQ_STAT, 32'h1);
		wr(OFS_CTL_THREE, 8'h10);
		wr(OFS_IRQ_CLR, 8'h01);
		pin(P_IRQ, 1'b0);
		pulse(1'b0);
		rdc(OFS_IRQ_STAT, 32'h0);
		rdc(OFS_CTL_THREE, 32'h90);
		wr(OFS_CTL_THREE, 8'h50);
		rdc(OFS_CTL_THREE, 32'h10);
		// masked by the enable register, then unmasked
		wr(OFS_IRQ_EN, 8'h02);
		wr(OFS_CTL_THREE, 8'h18);
		pulse(1'b0);
		rdc(OFS_IRQ_STAT, 32'h1);
		pin(P_IRQ, 1'b0);
		wr(OFS_IRQ_EN, 8'h03);
		pin(P_IRQ, 1'b1);
		wr(OFS_CTL_THREE, 8'h58);
		wr(OFS_IRQ_CLR, 8'h01);
		pin(P_IRQ, 1'b0);
		// drop detector in interrupt response
		wr(OFS_CTL_ONE, 8'h24);
		pulse(1'b1);
		pin(P_RST, 1'b0);
		pin(P_IRQ, 1'b1);
		rdc(OFS_IRQ_STAT, 32'h2);
		wr(OFS_CTL_ONE, 8'h64);
		wr(OFS_IRQ_CLR, 8'h02);
		pin(P_IRQ, 1'b0);
		// drop detector in reset response: no interrupt source
		wr(OFS_CTL_ONE, 8'h1c);
		DROP_DETECT <= 1'b1;
		repeat (3) @(posedge CLK);
		pin(P_RST, 1'b1);
		rdc(OFS_IRQ_STAT, 32'h0);
		DROP_DETECT <= 1'b0;
		wr(OFS_CTL_ONE, 8'h5c);
		repeat (2) @(posedge CLK);
		pin(P_RST, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			@(posedge CLK);
			OPCODE <= op_t[i];
			USER_MODE <= usr_t[i];
			CORE_VERSION <= ver_t[i];
			OPCODE_VALID <= 1'b1;
			@(posedge CLK);
			OPCODE_VALID <= 1'b0;
			cnt = 32'h0;
			repeat (5)
			begin
				@(posedge CLK);
				cnt = cnt + {31'h0, SYS_RESET_REQ};
			end
			chk(cnt, hit_t[i]);
		end
		// count over 16 cycles is exact whatever the counter phase
		for (int c = 0; c < 4; c++)
		begin
			wr(OFS_CLK_TWO, {div_t[c], 6'h15});
			cnt = 32'h0;
			repeat (16)
			begin
				@(posedge CLK);
				cnt = cnt + {31'h0, BUS_CLK_EN};
			end
			chk(cnt, en_t[c]);
			rdc(OFS_CLK_TWO, {24'h0, div_t[c], 6'h15});
		end
		final_report();
	end
endmodule : lvm_top_tb_top
`default_nettype wire
